// File: design/cpc_top.sv
// code protection configuration bytes with register port
// Operation
// - low bit0 zero protects program block 0
// - low bit1 zero protects program block 1
// - high bit7 zero protects data eeprom
// - high bit6 zero protects boot block
// - unused bits read as zero
// - flags only clearable by writes, set back to one only by reset
// - unprogrammed flags read as one
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cpc_top
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire cpc_pkg::cpc_req_s req_i,
    output logic [cpc_pkg::DATA_W-1:0] rdata_o,
    output cpc_pkg::cpc_prot_s protect_o
);
    import cpc_pkg::*;

    logic block0_protect_n;
    logic block1_protect_n;
    logic eeprom_protect_n;
    logic boot_protect_n;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    cpc_prot_s protect_reg;
    cpc_prot_s protect_next;
    wire logic wr_low;
    wire logic wr_high;
    wire logic [DATA_W-1:0] low_byte;
    wire logic [DATA_W-1:0] high_byte;
    wire logic [DATA_W-1:0] status_byte;

    assign wr_low = req_i.wr && (req_i.addr == OFF_LOW);
    assign wr_high = req_i.wr && (req_i.addr == OFF_HIGH);

    cpc_flag u_block0
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .wr_i(wr_low),
        .wdata_i(req_i.wdata[BIT_BLOCK0]),
        .flag_o(block0_protect_n)
    );

    cpc_flag u_block1
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .wr_i(wr_low),
        .wdata_i(req_i.wdata[BIT_BLOCK1]),
        .flag_o(block1_protect_n)
    );

    cpc_flag u_eeprom
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .wr_i(wr_high),
        .wdata_i(req_i.wdata[BIT_EEPROM]),
        .flag_o(eeprom_protect_n)
    );

    cpc_flag u_boot
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .wr_i(wr_high),
        .wdata_i(req_i.wdata[BIT_BOOT]),
        .flag_o(boot_protect_n)
    );

    // byte images, unused positions zero
    assign low_byte = {6'h00, block1_protect_n, block0_protect_n};
    assign high_byte = {eeprom_protect_n, boot_protect_n, 6'h00};
    assign status_byte = {4'h0, protect_next};

    assign rdata_next = !req_i.rd ? ZERO_BYTE :
                        (req_i.addr == OFF_LOW) ? (low_byte & LOW_MASK) :
                        (req_i.addr == OFF_HIGH) ? (high_byte & HIGH_MASK) :
                        (req_i.addr == OFF_STATUS) ? status_byte :
                        ZERO_BYTE;

    // protection active while flag is zero
    assign protect_next.eeprom = !eeprom_protect_n;
    assign protect_next.boot = !boot_protect_n;
    assign protect_next.block1 = !block1_protect_n;
    assign protect_next.block0 = !block0_protect_n;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rdata_reg <= ZERO_BYTE;
            protect_reg <= '0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            protect_reg <= protect_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign protect_o = protect_reg;

    // block 0 flag
    a_block0_read: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.rd && req_i.addr == OFF_LOW
        |=> rdata_o[BIT_BLOCK0] == $past(block0_protect_n))
        else $error("block 0 flag read wrong");

    a_block0_clear: assert property (@(posedge clk_i)
        disable iff (reset_i)
        wr_low && !req_i.wdata[BIT_BLOCK0]
        |=> !block0_protect_n)
        else $error("block 0 flag not cleared");

    a_block0_keep: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !(wr_low && !req_i.wdata[BIT_BLOCK0])
        |=> $stable(block0_protect_n))
        else $error("block 0 flag changed unasked");

    a_block0_no_set: assert property (@(posedge clk_i)
        disable iff (reset_i)
        wr_low && !block0_protect_n
        |=> !block0_protect_n)
        else $error("block 0 flag set by write");

    a_block0_follow: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !block0_protect_n
        |=> protect_o.block0)
        else $error("block 0 protect output missing");

    a_block0_open: assert property (@(posedge clk_i)
        disable iff (reset_i)
        block0_protect_n
        |=> !protect_o.block0)
        else $error("block 0 protect output stuck");

    // block 1 flag
    a_block1_read: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.rd && req_i.addr == OFF_LOW
        |=> rdata_o[BIT_BLOCK1] == $past(block1_protect_n))
        else $error("block 1 flag read wrong");

    a_block1_clear: assert property (@(posedge clk_i)
        disable iff (reset_i)
        wr_low && !req_i.wdata[BIT_BLOCK1]
        |=> !block1_protect_n)
        else $error("block 1 flag not cleared");

    a_block1_keep: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !(wr_low && !req_i.wdata[BIT_BLOCK1])
        |=> $stable(block1_protect_n))
        else $error("block 1 flag changed unasked");

    a_block1_no_set: assert property (@(posedge clk_i)
        disable iff (reset_i)
        wr_low && !block1_protect_n
        |=> !block1_protect_n)
        else $error("block 1 flag set by write");

    a_block1_follow: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !block1_protect_n
        |=> protect_o.block1)
        else $error("block 1 protect output missing");

    a_block1_open: assert property (@(posedge clk_i)
        disable iff (reset_i)
        block1_protect_n
        |=> !protect_o.block1)
        else $error("block 1 protect output stuck");

    // eeprom flag
    a_eeprom_read: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.rd && req_i.addr == OFF_HIGH
        |=> rdata_o[BIT_EEPROM] == $past(eeprom_protect_n))
        else $error("eeprom flag read wrong");

    a_eeprom_clear: assert property (@(posedge clk_i)
        disable iff (reset_i)
        wr_high && !req_i.wdata[BIT_EEPROM]
        |=> !eeprom_protect_n)
        else $error("eeprom flag not cleared");

    a_eeprom_keep: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !(wr_high && !req_i.wdata[BIT_EEPROM])
        |=> $stable(eeprom_protect_n))
        else $error("eeprom flag changed unasked");

    a_high_no_set: assert property (@(posedge clk_i)
        disable iff (reset_i)
        wr_high && !eeprom_protect_n
        |=> !eeprom_protect_n)
        else $error("eeprom flag set by write");

    a_eeprom_follow: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !eeprom_protect_n
        |=> protect_o.eeprom)
        else $error("eeprom protect output missing");

    a_eeprom_open: assert property (@(posedge clk_i)
        disable iff (reset_i)
        eeprom_protect_n
        |=> !protect_o.eeprom)
        else $error("eeprom protect output stuck");

    // boot flag
    a_boot_read: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.rd && req_i.addr == OFF_HIGH
        |=> rdata_o[BIT_BOOT] == $past(boot_protect_n))
        else $error("boot flag read wrong");

    a_boot_clear: assert property (@(posedge clk_i)
        disable iff (reset_i)
        wr_high && !req_i.wdata[BIT_BOOT]
        |=> !boot_protect_n)
        else $error("boot flag not cleared");

    a_boot_keep: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !(wr_high && !req_i.wdata[BIT_BOOT])
        |=> $stable(boot_protect_n))
        else $error("boot flag changed unasked");

    a_boot_no_set: assert property (@(posedge clk_i)
        disable iff (reset_i)
        wr_high && !boot_protect_n
        |=> !boot_protect_n)
        else $error("boot flag set by write");

    a_protect_follow: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !boot_protect_n
        |=> protect_o.boot)
        else $error("boot protect output missing");

    a_boot_open: assert property (@(posedge clk_i)
        disable iff (reset_i)
        boot_protect_n
        |=> !protect_o.boot)
        else $error("boot protect output stuck");

    // byte images and idle read data
    a_low_unused_zero: assert property (@(posedge clk_i)
        disable iff (reset_i)
        $past(req_i.rd) && $past(req_i.addr) == OFF_LOW
        |-> (rdata_o & ~LOW_MASK) == ZERO_BYTE)
        else $error("unused low bits not zero");

    a_high_unused_zero: assert property (@(posedge clk_i)
        disable iff (reset_i)
        $past(req_i.rd) && $past(req_i.addr) == OFF_HIGH
        |-> (rdata_o & ~HIGH_MASK) == ZERO_BYTE)
        else $error("unused high bits not zero");

    a_low_full_byte: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.rd && req_i.addr == OFF_LOW
        |=> rdata_o == {6'h00, $past(block1_protect_n),
        $past(block0_protect_n)})
        else $error("low byte image wrong");

    a_high_full_byte: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.rd && req_i.addr == OFF_HIGH
        |=> rdata_o == {$past(eeprom_protect_n),
        $past(boot_protect_n), 6'h00})
        else $error("high byte image wrong");

    a_unmapped_zero: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.rd && req_i.addr != OFF_LOW && req_i.addr != OFF_HIGH
        && req_i.addr != OFF_STATUS
        |=> rdata_o == ZERO_BYTE)
        else $error("unmapped read not zero");

    a_rdata_idle: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !req_i.rd
        |=> rdata_o == ZERO_BYTE)
        else $error("read data without read strobe");

    a_status_read: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.rd && req_i.addr == OFF_STATUS
        |=> rdata_o == {4'h0, !$past(eeprom_protect_n),
        !$past(boot_protect_n), !$past(block1_protect_n),
        !$past(block0_protect_n)})
        else $error("status byte wrong");

    // reset state
    a_reset_unprot: assert property (@(posedge clk_i)
        $past(reset_i)
        |-> block0_protect_n && block1_protect_n
        && eeprom_protect_n && boot_protect_n)
        else $error("flag not one after reset");

    a_reset_outputs: assert property (@(posedge clk_i)
        $past(reset_i)
        |-> rdata_o == ZERO_BYTE && protect_o == '0)
        else $error("outputs not idle after reset");
endmodule : cpc_top
`default_nettype wire

// File: design/cpc_pkg.sv
// package: code protection configuration constants and types
package cpc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFF_LOW = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_HIGH = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h2;
    localparam int BIT_BLOCK0 = 0;
    localparam int BIT_BLOCK1 = 1;
    localparam int BIT_EEPROM = 7;
    localparam int BIT_BOOT = 6;
    localparam logic [DATA_W-1:0] LOW_MASK = 8'h03;
    localparam logic [DATA_W-1:0] HIGH_MASK = 8'hC0;
    localparam logic [DATA_W-1:0] LOW_RESET = 8'h03;
    localparam logic [DATA_W-1:0] HIGH_RESET = 8'hC0;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cpc_req_s;

    typedef struct packed {
        logic eeprom;
        logic boot;
        logic block1;
        logic block0;
    } cpc_prot_s;
endpackage : cpc_pkg

// File: design/cpc_flag.sv
// one clear-only protection flag
`timescale 1ns/100ps
`default_nettype none
module cpc_flag
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    output logic flag_o
);
    logic flag_reg;
    logic flag_next;

    // writes can only lower the flag
    assign flag_next = (wr_i && !wdata_i) ? 1'b0 : flag_reg;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            flag_reg <= 1'b1;
        else
            flag_reg <= flag_next;
    end

    assign flag_o = flag_reg;

    a_flag_no_set: assert property (@(posedge clk_i)
        disable iff (reset_i)
        !$past(reset_i) && !$past(flag_reg) |-> !flag_reg)
        else $error("cleared flag rose again");
endmodule : cpc_flag
`default_nettype wire

// File: tb/cpc_top_test.sv
// self-checking bench for the code protection configuration block
`timescale 1ns/100ps
`default_nettype none
module cpc_top_test;
    import cpc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    cpc_req_s req = '0;
    logic [DATA_W-1:0] rdata;
    cpc_prot_s prot;
    int fails = 0;
    int checks_done = 0;
    cpc_top dut_u (.clk_i(clk), .reset_i(reset), .req_i(req),
        .rdata_o(rdata), .protect_o(prot));
    always #2.5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr
    // read data checked one cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd
    task automatic t_reset();
        rd(OFF_LOW, LOW_RESET);
        rd(OFF_HIGH, HIGH_RESET);
        chk({4'h0, prot}, 8'h00);
        rd(OFF_STATUS, ZERO_BYTE);
        rd(4'hF, ZERO_BYTE);
        $display("test reset values done");
    endtask : t_reset
    task automatic t_low();
        wr(OFF_LOW, 8'hFE);
        rd(OFF_LOW, 8'h02);
        chk({4'h0, prot}, 8'h01);
        wr(OFF_LOW, 8'hFF);
        rd(OFF_LOW, 8'h02);
        wr(OFF_LOW, 8'h01);
        rd(OFF_LOW, 8'h00);
        chk({4'h0, prot}, 8'h03);
        $display("test low byte done");
    endtask : t_low
    task automatic t_high();
        wr(OFF_HIGH, 8'hBF);
        rd(OFF_HIGH, 8'h80);
        chk({4'h0, prot}, 8'h07);
        wr(OFF_HIGH, 8'h7F);
        rd(OFF_HIGH, 8'h00);
        chk({4'h0, prot}, 8'h0F);
        rd(OFF_STATUS, 8'h0F);
        $display("test high byte done");
    endtask : t_high
    task automatic t_rerun();
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        wr(4'hF, 8'h00);
        rd(OFF_LOW, LOW_RESET);
        rd(OFF_HIGH, HIGH_RESET);
        chk({4'h0, prot}, 8'h00);
        $display("test second reset done");
    endtask : t_rerun
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_low();
        t_high();
        t_rerun();
        results();
    end
    initial
    begin
        #5000;
        fails++;
        results();
    end
endmodule : cpc_top_test
`default_nettype wire
